// ===== test/bthi_core_tb_top.sv
// Purpose: Self-checking bench for the host interface core.
// Assumes: Synchronised inputs settle within six cycles.
// Notes: The host and RAM side is bthi_host_model.
`timescale 1ns/1ps
`include "bthi_regs.svh"
module bthi_core_tb_top;
   logic clk, arst_n, master_reset_n, cs_n, rd_n, wr_n, address_release;
   logic role_select_pin, lock, external_abort_n, cmd_valid, cmd_done;
   logic mem_req, mem_write, ram_select_in_n, dma_grant, data_oe, addr_oe;
   logic command_strobe_n, mem_done, dma_request, ram_select_out_n, stb;
   logic stb_prev;
   logic ram_read_strobe_n, ram_write_strobe_n, role_is_rt, parity_ok, abort;
   logic [15:0] data_in, data_out, addr_out, mem_addr, mem_wdata, host_d;
   logic [15:0] last_addr, last_data, rd_v, exp_v, ctrl_e;
   logic [5:0] straps, exp_s;
   logic [4:0] terminal_addr;
   logic [3:0] grant_delay;
   logic [2:0] reg_addr;
   int err_total, compares, cycles, stb_cyc, stb_fall, seed, n0, f0;
   assign data_in = data_oe ? data_out : host_d;
   assign stb = ~(ram_read_strobe_n & ram_write_strobe_n);
   bthi_core dut_u (.clk(clk), .arst_n(arst_n),
      .master_reset_n(master_reset_n), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .reg_addr(reg_addr),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr_out(addr_out),
      .addr_oe(addr_oe), .address_release(address_release),
      .terminal_addr_bit0(straps[0]), .terminal_addr_mid(straps[3:1]),
      .terminal_addr_bit_top(straps[4]),
      .terminal_addr_parity_pin(straps[5]),
      .role_select_pin(role_select_pin), .lock(lock),
      .external_abort_n(external_abort_n), .cmd_valid(cmd_valid),
      .cmd_done(cmd_done), .command_strobe_n(command_strobe_n),
      .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_done(mem_done),
      .dma_request(dma_request), .dma_grant(dma_grant),
      .ram_select_in_n(ram_select_in_n),
      .ram_select_out_n(ram_select_out_n),
      .ram_read_strobe_n(ram_read_strobe_n),
      .ram_write_strobe_n(ram_write_strobe_n), .role_is_rt(role_is_rt),
      .terminal_addr(terminal_addr), .parity_ok(parity_ok), .abort(abort));
   bthi_host_model host_u (.clk(clk), .dma_request(dma_request),
      .grant_delay(grant_delay), .ram_select_out_n(ram_select_out_n),
      .ram_write_strobe_n(ram_write_strobe_n), .addr_out(addr_out),
      .addr_oe(addr_oe),
      .data_out(data_out), .data_oe(data_oe), .dma_grant(dma_grant),
      .last_addr(last_addr), .last_data(last_data));
   function automatic logic [5:0] odd_straps(input logic [31:0] r);
      return {~^r[4:0], r[4:0]};
   endfunction : odd_straps
   task automatic chk(input string n, input logic [15:0] e, g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic finish_test();
      if (err_total == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic reg_wr(input logic [2:0] a, input logic [15:0] d,
      input logic s);
      @(posedge clk);
      reg_addr <= a;
      host_d <= d;
      cs_n <= !s;
      wr_n <= 1'b0;
      repeat (5) @(posedge clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      host_d <= ~d;
      settle(4);
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      settle(4);
      d = data_out;
      chk("rdoe", 16'h1, {15'h0, data_oe});
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask : reg_rd
   task automatic mem_op(input logic w, input logic [15:0] a, d,
      input logic r);
      int n;
      @(posedge clk);
      grant_delay <= 4'($random(seed));
      address_release <= r;
      mem_write <= w;
      mem_addr <= a;
      mem_wdata <= d;
      mem_req <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (mem_done !== 1'b1 && n < 80);
      chk("done", 16'h1, {15'h0, n < 80});
      @(posedge clk);
      mem_req <= 1'b0;
      settle(3);
   endtask : mem_op
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(negedge clk)
   begin
      cycles++;
      if (stb === 1'b1 && dma_grant !== 1'b1)
         chk("grant", 16'h1, {15'h0, dma_grant});
      if (stb === 1'b1 && ram_select_out_n !== 1'b0)
         chk("rsel", 16'h0, 16'h1);
      if (addr_oe !== 1'b0 && address_release === 1'b0)
         chk("aoe", 16'h0, 16'h1);
      if (cs_n === 1'b1 && stb !== 1'b1 && data_oe !== 1'b0)
         chk("doe", 16'h0, 16'h1);
      stb_fall += int'(stb === 1'b1 && stb_prev !== 1'b1);
      stb_prev <= stb;
      stb_cyc += int'(stb === 1'b1);
      if (cycles == 20000)
      begin
         err_total++;
         finish_test();
      end
   end
   initial
   begin
      seed = 32'h3f9dc46c;
      {arst_n, master_reset_n, cmd_valid, cmd_done, mem_req, mem_write} = '0;
      {cs_n, rd_n, wr_n, address_release, external_abort_n} = '1;
      lock = 1'b0;
      {role_select_pin, ram_select_in_n} = 2'b11;
      {mem_addr, mem_wdata, host_d, reg_addr, grant_delay, ctrl_e} = '0;
      {err_total, compares, cycles, stb_cyc, stb_fall} = '0;
      exp_s = odd_straps($random(seed));
      straps = exp_s;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (12) @(posedge clk);
      master_reset_n <= 1'b1;
      settle(8);
      chk("ta", {11'h0, exp_s[4:0]}, {11'h0, terminal_addr});
      chk("par", 16'h1, {15'h0, parity_ok});
      @(posedge clk);
      straps <= odd_straps($random(seed));
      settle(8);
      chk("hold", {11'h0, exp_s[4:0]}, {11'h0, terminal_addr});
      reg_rd(`BTHI_REG_TADDR, rd_v);
      chk("tareg", {10'h0, exp_s}, {10'h0, rd_v[5:0]});
      for (int i = 0; i < 6; i++)
      begin
         exp_v = 16'($random(seed)) & 16'hFFFD;
         reg_wr(`BTHI_REG_CTRL, exp_v, i != 2);
         ctrl_e = (i != 2) ? exp_v : ctrl_e;
         reg_rd(`BTHI_REG_CTRL, rd_v);
         chk("ctrl", ctrl_e, rd_v);
         chk("role", {15'h0, ctrl_e[0]}, {15'h0, role_is_rt});
      end
      @(posedge clk);
      lock <= 1'b1;
      role_select_pin <= ~ctrl_e[0];
      reg_wr(`BTHI_REG_CTRL, ctrl_e ^ 16'h0001, 1'b1);
      chk("lock", {15'h0, ~ctrl_e[0]}, {15'h0, role_is_rt});
      reg_rd(`BTHI_REG_CTRL, rd_v);
      chk("lkrd", ctrl_e, rd_v);
      @(posedge clk);
      straps <= exp_s ^ 6'h21;
      master_reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      master_reset_n <= 1'b1;
      settle(8);
      chk("lta", {11'h0, exp_s[4:0]}, {11'h0, terminal_addr});
      @(posedge clk);
      lock <= 1'b0;
      straps <= odd_straps($random(seed)) ^ 6'h20;
      master_reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      master_reset_n <= 1'b1;
      settle(8);
      chk("bad", 16'h0, {15'h0, parity_ok});
      reg_rd(`BTHI_REG_CTRL, rd_v);
      chk("rst", `BTHI_CTRL_RESET, rd_v);
      @(posedge clk);
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      settle(3);
      chk("cs1", 16'h0, {15'h0, command_strobe_n});
      @(posedge clk);
      cmd_done <= 1'b1;
      @(posedge clk);
      cmd_done <= 1'b0;
      settle(3);
      chk("cs2", 16'h1, {15'h0, command_strobe_n});
      for (int i = 0; i < 6; i++)
      begin
         {n0, f0} = {stb_cyc, stb_fall};
         exp_v = 16'($random(seed));
         mem_op(i < 4, exp_v, ~exp_v, i != 5);
         chk("scyc", 16'(`BTHI_STROBE_CYC), 16'(stb_cyc - n0));
         chk("fall", 16'h1, 16'(stb_fall - f0));
         if (i < 4)
            chk("wd", ~exp_v, last_data);
         if (i < 4)
            chk("wa", exp_v, last_addr);
      end
      @(posedge clk);
      grant_delay <= 4'hF;
      mem_req <= 1'b1;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
      external_abort_n <= 1'b0;
      settle(5);
      chk("abt", 16'h1, {15'h0, abort});
      chk("dreq", 16'h0, {15'h0, dma_request});
      chk("acmd", 16'h1, {15'h0, command_strobe_n});
      @(posedge clk);
      mem_req <= 1'b0;
      external_abort_n <= 1'b1;
      ram_select_in_n <= 1'b0;
      settle(1);
      chk("npdp", 16'h1, {15'h0, ram_select_out_n});
      reg_wr(`BTHI_REG_CTRL, 16'h0002, 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         ram_select_in_n <= 1'(i);
         settle(4);
         chk("pdp", 16'(i), {15'h0, ram_select_out_n});
      end
      finish_test();
   end
endmodule : bthi_core_tb_top

// ===== test/bthi_host_model.sv
// Purpose: Host CPU and shared RAM seen from the device.
// Assumes: Grant follows a request after grant_delay plus one cycles.
// Notes: Keeps the last word that the device wrote.
`timescale 1ns/1ps
module bthi_host_model (
   input wire logic clk,
   input wire logic dma_request,
   input wire logic [3:0] grant_delay,
   input wire logic ram_select_out_n,
   input wire logic ram_write_strobe_n,
   input wire logic [15:0] addr_out,
   input wire logic addr_oe,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   output logic dma_grant,
   output logic [15:0] last_addr,
   output logic [15:0] last_data
);
   logic [3:0] wait_q;
   initial
   begin
      dma_grant = 1'b0;
      wait_q = 4'h0;
      last_addr = 16'h0000;
      last_data = 16'h0000;
   end
   always @(posedge clk)
   begin
      if (!dma_request)
      begin
         dma_grant <= 1'b0;
         wait_q <= 4'h0;
      end
      else if (wait_q >= grant_delay)
         dma_grant <= 1'b1;
      else
         wait_q <= wait_q + 4'h1;
      if (!ram_write_strobe_n && !ram_select_out_n && data_oe)
      begin
         if (addr_oe)
            last_addr <= addr_out;
         last_data <= data_out;
      end
   end
endmodule : bthi_host_model

// ===== verilog/bthi_core.sv
// Purpose: Host port, address strap capture, role and abort logic.
// Assumes: One 20 MHz clock; the master reset, abort and write strobe pins pass a three-stage synchroniser.
// Notes: Two-way pins are split into in, out and output enable.
`timescale 1ns/1ps
`include "bthi_regs.svh"

module bthi_core #(
   parameter logic ROLE_PIN_HIGH_IS_RT = 1'b1,
   parameter int RST_MIN_CYC = `BTHI_RST_MIN_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic master_reset_n,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   input wire logic [2:0] reg_addr,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [15:0] addr_out,
   output logic addr_oe,
   input wire logic address_release,
   input wire logic terminal_addr_bit0,
   input wire logic [3:1] terminal_addr_mid,
   input wire logic terminal_addr_bit_top,
   input wire logic terminal_addr_parity_pin,
   input wire logic role_select_pin,
   input wire logic lock,
   input wire logic external_abort_n,
   input wire logic cmd_valid,
   input wire logic cmd_done,
   output logic command_strobe_n,
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_done,
   output logic dma_request,
   input wire logic dma_grant,
   input wire logic ram_select_in_n,
   output logic ram_select_out_n,
   output logic ram_read_strobe_n,
   output logic ram_write_strobe_n,
   output logic role_is_rt,
   output logic [4:0] terminal_addr,
   output logic parity_ok,
   output logic abort
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [3:0] rcnt;
      logic cap_done;
      logic [4:0] taddr;
      logic par;
      logic [15:0] ctrl;
      logic cmd;
      bthi_pkg::bthi_mem_e ms;
      logic [1:0] scnt;
      logic wr_seen;
      logic [15:0] dout;
      logic dvalid;
      logic done;
   } bthi_core_s;
   bthi_core_s st_q, st_d;
   logic [2:0] pin_now;
   logic master_reset_n_act, xabort, wr_ev, rd_act, own_mem;
   assign pin_now = {master_reset_n, external_abort_n, ~wr_n};
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = pin_now;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      master_reset_n_act = (st_q.s2[2] == st_q.s3[2]) && !st_q.s3[2];
      xabort = (st_q.s2[1] == st_q.s3[1]) && !st_q.s3[1];
      wr_ev = st_q.s2[0] && st_q.s3[0] && !st_q.wr_seen;
      st_d.done = 1'b0;
      if (master_reset_n_act)
      begin
         st_d.rcnt = (st_q.rcnt == 4'hF) ? 4'hF : st_q.rcnt + 4'h1;
         if (!lock || !st_q.cap_done)
         begin
            st_d.taddr = {terminal_addr_bit_top, terminal_addr_mid,
               terminal_addr_bit0};
            st_d.par = terminal_addr_parity_pin;
         end
         st_d.ctrl = `BTHI_CTRL_RESET;
         st_d.cmd = 1'b0;
         st_d.ms = bthi_pkg::MEM_IDLE;
         st_d.dvalid = 1'b0;
         st_d.wr_seen = 1'b0;
      end
      else
      begin
         if (32'(st_q.rcnt) >= RST_MIN_CYC)
            st_d.cap_done = 1'b1;
         st_d.rcnt = 4'h0;
         st_d.wr_seen = st_q.s2[0] && st_q.s3[0];
         if (wr_ev && !cs_n)
            if (reg_addr == `BTHI_REG_CTRL)
            begin
               st_d.ctrl = data_in;
               if (lock)
                  st_d.ctrl[`BTHI_CTRL_ROLE_BIT] =
                     st_q.ctrl[`BTHI_CTRL_ROLE_BIT];
            end
         if (cmd_valid)
            st_d.cmd = 1'b1;
         else if (cmd_done)
            st_d.cmd = 1'b0;
         case (st_q.ms)
            bthi_pkg::MEM_IDLE:
               if (mem_req)
                  st_d.ms = bthi_pkg::MEM_WAIT;
            bthi_pkg::MEM_WAIT:
               if (dma_grant)
               begin
                  st_d.ms = bthi_pkg::MEM_STROBE;
                  st_d.scnt = 2'h0;
               end
            bthi_pkg::MEM_STROBE:
            begin
               st_d.scnt = st_q.scnt + 2'h1;
               if (st_q.scnt == 2'(`BTHI_STROBE_CYC - 1))
               begin
                  st_d.ms = bthi_pkg::MEM_GAP;
                  st_d.done = 1'b1;
               end
            end
            bthi_pkg::MEM_GAP:
               st_d.ms = bthi_pkg::MEM_IDLE;
            default:
               st_d.ms = bthi_pkg::MEM_IDLE;
         endcase
         if (xabort)
         begin
            st_d.cmd = 1'b0;
            st_d.ms = bthi_pkg::MEM_IDLE;
            st_d.done = 1'b0;
         end
         st_d.dvalid = !cs_n && !rd_n;
         case (reg_addr)
            `BTHI_REG_CTRL: st_d.dout = st_q.ctrl;
            `BTHI_REG_TADDR:
               st_d.dout = {10'h000, st_q.par, st_q.taddr};
            `BTHI_REG_STAT: st_d.dout = {12'h000, st_q.cmd, lock,
               role_is_rt, parity_ok};
            default: st_d.dout = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Synchroniser stages start at idle pin levels, so no false abort.
         st_q <= '0;
         st_q.s1 <= 3'h6;
         st_q.s2 <= 3'h6;
         st_q.s3 <= 3'h6;
      end
      else
         st_q <= st_d;
   end
   assign rd_act = !cs_n && !rd_n && st_q.dvalid;
   assign own_mem = (st_q.ms == bthi_pkg::MEM_STROBE);
   assign data_out = own_mem && st_q.ms != bthi_pkg::MEM_IDLE && mem_write ?
      mem_wdata : st_q.dout;
   assign data_oe = rd_act || (own_mem && mem_write);
   assign addr_out = mem_addr;
   assign addr_oe = address_release && st_q.ms != bthi_pkg::MEM_IDLE &&
      st_q.ms != bthi_pkg::MEM_GAP && dma_grant;
   assign ram_select_out_n = own_mem ? 1'b0 :
      (st_q.ctrl[`BTHI_CTRL_PDP_BIT] ? ram_select_in_n : 1'b1);
   assign ram_read_strobe_n = !(own_mem && !mem_write);
   assign ram_write_strobe_n = !(own_mem && mem_write);
   assign mem_done = st_q.done;
   assign dma_request = st_q.ms == bthi_pkg::MEM_WAIT ||
      st_q.ms == bthi_pkg::MEM_STROBE;
   assign command_strobe_n = !st_q.cmd;
   assign role_is_rt = lock ? (role_select_pin == ROLE_PIN_HIGH_IS_RT) :
      st_q.ctrl[`BTHI_CTRL_ROLE_BIT];
   assign terminal_addr = st_q.taddr;
   assign parity_ok = ^{st_q.par, st_q.taddr};
   assign abort = xabort;

   property p_strobe_needs_grant;
      @(posedge clk) disable iff (!arst_n)
      $fell(ram_read_strobe_n) |-> $past(dma_grant);
   endproperty
   a_strobe_needs_grant: assert property (p_strobe_needs_grant)
      else $error("Read strobe without grant.");
   sequence s_strobe;
      !ram_write_strobe_n [*2] ##1 ram_write_strobe_n;
   endsequence
   property p_write_pulse;
      @(posedge clk) disable iff (!arst_n)
      ($fell(ram_write_strobe_n) && external_abort_n) |-> s_strobe or
         ##[0:3] !external_abort_n;
   endproperty
   a_write_pulse: assert property (p_write_pulse)
      else $error("Write strobe not a two cycle pulse.");
   property p_addr_release;
      @(posedge clk) disable iff (!arst_n)
      addr_oe |-> address_release;
   endproperty
   a_addr_release: assert property (p_addr_release)
      else $error("Address driven without release.");
   property p_read_cs;
      @(posedge clk) disable iff (!arst_n)
      data_oe && !own_mem |-> !cs_n && !rd_n;
   endproperty
   a_read_cs: assert property (p_read_cs)
      else $error("Data driven without chip select.");
   property p_cmd;
      @(posedge clk) disable iff (!arst_n)
      (cmd_valid && !master_reset_n_act && !xabort) |=> !command_strobe_n;
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("Command strobe missing.");
   property p_pass;
      @(posedge clk) disable iff (!arst_n)
      (st_q.ctrl[`BTHI_CTRL_PDP_BIT] && !own_mem) |->
         ram_select_out_n == ram_select_in_n;
   endproperty
   a_pass: assert property (p_pass)
      else $error("RAM select not passed through.");
   property p_abort;
      @(posedge clk) disable iff (!arst_n)
      xabort && !master_reset_n_act |=>
         st_q.ms == bthi_pkg::MEM_IDLE && command_strobe_n;
   endproperty
   a_abort: assert property (p_abort)
      else $error("Abort left activity running.");
   property p_lock;
      @(posedge clk) disable iff (!arst_n)
      lock && st_q.cap_done && $past(lock) |=> $stable(st_q.taddr);
   endproperty
   a_lock: assert property (p_lock)
      else $error("Terminal address changed under lock.");
   property p_write_grant;
      @(posedge clk) disable iff (!arst_n)
      $fell(ram_write_strobe_n) |-> $past(dma_grant);
   endproperty
   a_write_grant: assert property (p_write_grant)
      else $error("Write strobe without grant.");
   sequence s_rd_strobe;
      !ram_read_strobe_n [*2] ##1 ram_read_strobe_n;
   endsequence
   property p_read_pulse;
      @(posedge clk) disable iff (!arst_n)
      ($fell(ram_read_strobe_n) && external_abort_n) |-> s_rd_strobe or
         ##[0:3] !external_abort_n;
   endproperty
   a_read_pulse: assert property (p_read_pulse)
      else $error("Read strobe not a two cycle pulse.");
   property p_own_select;
      @(posedge clk) disable iff (!arst_n)
      (!ram_read_strobe_n || !ram_write_strobe_n) |-> !ram_select_out_n;
   endproperty
   a_own_select: assert property (p_own_select)
      else $error("RAM select missing during own access.");
   property p_bus_release;
      @(posedge clk) disable iff (!arst_n)
      cs_n && !own_mem |-> !data_oe;
   endproperty
   a_bus_release: assert property (p_bus_release)
      else $error("Data bus driven while idle.");
   property p_addr_idle;
      @(posedge clk) disable iff (!arst_n)
      st_q.ms == bthi_pkg::MEM_IDLE |-> !addr_oe;
   endproperty
   a_addr_idle: assert property (p_addr_idle)
      else $error("Address bus driven while idle.");
   property p_master_reset;
      @(posedge clk) disable iff (!arst_n)
      master_reset_n_act |=> st_q.ctrl == `BTHI_CTRL_RESET && command_strobe_n &&
         st_q.ms == bthi_pkg::MEM_IDLE;
   endproperty
   a_master_reset: assert property (p_master_reset)
      else $error("Master reset left state behind.");
   property p_reg_store;
      @(posedge clk) disable iff (!arst_n)
      (wr_ev && !cs_n && !master_reset_n_act && !lock &&
         reg_addr == `BTHI_REG_CTRL) |=> st_q.ctrl == $past(data_in);
   endproperty
   a_reg_store: assert property (p_reg_store)
      else $error("Control write not stored.");
endmodule : bthi_core

// ===== verilog/bthi_pkg.sv
// Purpose: Types for the bus terminal host interface.
// Assumes: Nothing.
// Notes: Holds the memory sequencer states.
package bthi_pkg;
   typedef enum logic [1:0] {MEM_IDLE, MEM_WAIT, MEM_STROBE, MEM_GAP}
      bthi_mem_e;
endpackage : bthi_pkg

// ===== verilog/bthi_regs.svh
// Purpose: Constants for the bus terminal host interface.
// Assumes: 20 MHz clock, 50 ns period.
// Notes: Register indices are local choices; the host port has 3 address bits.
`ifndef BTHI_REGS_SVH
`define BTHI_REGS_SVH
`define BTHI_REG_CTRL 3'h0
`define BTHI_REG_TADDR 3'h1
`define BTHI_REG_STAT 3'h2
`define BTHI_CTRL_ROLE_BIT 0
`define BTHI_CTRL_PDP_BIT 1
`define BTHI_CTRL_RESET 16'h0000
`define BTHI_CLK_NS 50
`define BTHI_RST_MIN_NS 500
`define BTHI_RST_MIN_CYC ((`BTHI_RST_MIN_NS + `BTHI_CLK_NS - 1) / `BTHI_CLK_NS)
`define BTHI_STROBE_CYC 2
`endif
